// file: logic/urb_rx_status.sv
`timescale 1ns/100ps
`include "urb_regs.svh"

// Operation
// - complete flag is one exactly while the buffer holds unread frames
// - clearing receiver enable empties the buffer and drops the complete flag
// - complete interrupt requested while its enable, global enable and flag are set
// - error flags stored per entry, flags of the oldest entry are shown
// - data read advances the read position; read status first
// - software cannot write the three error flags
// - error flags never raise an interrupt
// - frame error is one when the first stop bit sampled zero
// - only the first stop bit is checked, stop count setting ignored
// - two-entry buffer; overrun on full buffer, held frame and new start
// - overrun marks lost frames; clears on the next successful transfer
// - parity error reads zero while parity checking is disabled
// - parity checked only with enable bit set; odd select picks the sense
// - checker compares data parity with parity bit, result stored with data
// - parity error only if checking was on at arrival; valid until read
// - disabling the receiver is immediate, the frame being shifted is lost
// - receiver releases the pin override while disabled
// - ninth bit stored per entry and shown; read it before the low byte
// - unused upper data bits read as zero for short characters
module urb_rx_status #(
    parameter int DEPTH = `URB_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic rx_enable_bit,
    input wire logic rx_complete_irq_enable,
    input wire logic global_irq_enable,
    input wire logic parity_enable_bit,
    input wire logic parity_odd_select,
    input wire logic [`URB_CSZ_W-1:0] char_size_field,
    input wire logic start_detect,
    input wire logic bit_strobe,
    input wire logic bit_value,
    input wire logic data_read,
    output logic [`URB_BYTE_W-1:0] serial_data_location,
    output logic rx_ninth_bit,
    output logic frame_error_flag,
    output logic overrun_flag,
    output logic parity_error_flag,
    output logic rx_complete_flag,
    output logic rx_complete_irq,
    output logic rx_pin_override,
    output logic rx_busy
);
    import urb_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = PW + 1;

    // pointers wrap by carry-out, so only powers of two are served
    generate
        if ((DEPTH < 2) || (DEPTH != (1 << PW)))
        begin : g_bad_depth
            $error("urb_rx_status: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    urb_rx_state_t state_r;
    urb_rx_state_t state_nxt;

    logic [`URB_DATA_W-1:0] shift_r;
    logic [`URB_IDX_W-1:0] bit_idx_r;
    logic [`URB_IDX_W-1:0] bits_r;
    logic [`URB_IDX_W-1:0] bits_nxt;
    logic par_on_r;
    logic par_odd_r;
    logic fe_r;
    logic pe_r;
    logic dor_pend_r;

    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW-1:0] rd_ptr_nxt;
    logic [CW-1:0] count_r;

    logic full;
    logic have_data;
    logic start_ok;
    logic last_data;
    logic frame_done;
    logic held;
    logic push;
    logic pop;
    logic overrun_hit;
    logic wr_fe;
    logic [`URB_ENT_W-1:0] wr_entry;
    logic [`URB_ENT_W-1:0] rd_entry;

    // buffer occupancy
    assign full = (count_r == CW'(DEPTH));
    assign have_data = (count_r != '0);

    // a start is taken when idle or when a finished frame still waits
    assign start_ok = rx_enable_bit && start_detect &&
        ((state_r == URB_ST_IDLE) || (state_r == URB_ST_HOLD));

    assign last_data = (state_r == URB_ST_DATA) && bit_strobe &&
        (bit_idx_r == (bits_r - `URB_IDX_ONE));

    // first stop bit ends the frame; a second one is never looked at
    assign frame_done = rx_enable_bit && bit_strobe &&
        (state_r == URB_ST_STOP);

    assign held = rx_enable_bit && (state_r == URB_ST_HOLD);

    // move the finished frame whenever there is room
    assign push = (frame_done || held) && !full;

    // a read of an empty buffer is simply dropped
    assign pop = rx_enable_bit && data_read && have_data;

    // buffer full, frame held, new start: the held frame is lost
    assign overrun_hit = start_ok && held && full;

    // the stop bit is still on the line in the cycle the frame is taken
    assign wr_fe = (state_r == URB_ST_STOP) ? !bit_value : fe_r;

    // flags travel with their own frame through the buffer
    always_comb
    begin
        wr_entry = `URB_ENT_RST;
        wr_entry[`URB_DATA_W-1:0] = shift_r;
        wr_entry[`URB_FE_BIT] = wr_fe;
        wr_entry[`URB_DOR_BIT] = dor_pend_r;
        wr_entry[`URB_PE_BIT] = pe_r;
    end

    // character length from the size field; reserved codes act as eight bits
    always_comb
    begin
        if (char_size_field == `URB_CSZ_NINE)
        begin
            bits_nxt = `URB_BITS_NINE;
        end
        else if (char_size_field <= `URB_CSZ_MAX_STD)
        begin
            bits_nxt = `URB_CSZ_BASE + {1'b0, char_size_field};
        end
        else
        begin
            bits_nxt = `URB_BITS_EIGHT;
        end
    end

    // sequencer; losing the enable aborts whatever is under way
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            URB_ST_IDLE:
            begin
                if (start_ok)
                begin
                    state_nxt = URB_ST_DATA;
                end
            end
            URB_ST_DATA:
            begin
                if (last_data)
                begin
                    state_nxt = par_on_r ? URB_ST_PAR : URB_ST_STOP;
                end
            end
            URB_ST_PAR:
            begin
                if (bit_strobe)
                begin
                    state_nxt = URB_ST_STOP;
                end
            end
            URB_ST_STOP:
            begin
                if (bit_strobe)
                begin
                    state_nxt = full ? URB_ST_HOLD : URB_ST_IDLE;
                end
            end
            URB_ST_HOLD:
            begin
                if (start_ok)
                begin
                    state_nxt = URB_ST_DATA;
                end
                else if (!full)
                begin
                    state_nxt = URB_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = URB_ST_IDLE;
            end
        endcase
        if (!rx_enable_bit)
        begin
            state_nxt = URB_ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= URB_ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // frame format is latched at the start so a mid-frame change cannot split it
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bits_r <= `URB_BITS_EIGHT;
            par_on_r <= 1'b0;
            par_odd_r <= 1'b0;
        end
        else if (start_ok)
        begin
            bits_r <= bits_nxt;
            par_on_r <= parity_enable_bit;
            par_odd_r <= parity_odd_select;
        end
    end

    // data bits arrive lsb first; unused upper bits stay cleared
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_r <= `URB_SHIFT_RST;
            bit_idx_r <= `URB_IDX_RST;
        end
        else if (start_ok)
        begin
            shift_r <= `URB_SHIFT_RST;
            bit_idx_r <= `URB_IDX_RST;
        end
        else if (rx_enable_bit && bit_strobe && (state_r == URB_ST_DATA))
        begin
            shift_r[bit_idx_r] <= bit_value;
            bit_idx_r <= bit_idx_r + `URB_IDX_ONE;
        end
    end

    // parity check: even expects data xor parity bit to be zero
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pe_r <= 1'b0;
        end
        else if (start_ok)
        begin
            pe_r <= 1'b0;
        end
        else if (rx_enable_bit && bit_strobe && (state_r == URB_ST_PAR))
        begin
            pe_r <= par_on_r && ((^shift_r) ^ bit_value ^ par_odd_r);
        end
    end

    // stop bit value kept while the frame waits for room
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fe_r <= 1'b0;
        end
        else if (frame_done)
        begin
            fe_r <= !bit_value;
        end
    end

    // lost-frame mark rides on the next frame that gets into the buffer
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dor_pend_r <= 1'b0;
        end
        else if (!rx_enable_bit)
        begin
            dor_pend_r <= 1'b0;
        end
        else if (overrun_hit)
        begin
            dor_pend_r <= 1'b1;
        end
        else if (push)
        begin
            dor_pend_r <= 1'b0;
        end
    end

    // read position; the store is addressed with the next value
    always_comb
    begin
        rd_ptr_nxt = rd_ptr_r;
        if (!rx_enable_bit)
        begin
            rd_ptr_nxt = '0;
        end
        else if (pop)
        begin
            rd_ptr_nxt = rd_ptr_r + PW'(1);
        end
    end

    // pointers and count; disabling flushes every unread frame
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else if (!rx_enable_bit)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            rd_ptr_r <= rd_ptr_nxt;
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + PW'(1);
            end
            if (push && !pop)
            begin
                count_r <= count_r + CW'(1);
            end
            else if (pop && !push)
            begin
                count_r <= count_r - CW'(1);
            end
        end
    end

    urb_fifo_mem #(
        .WIDTH(`URB_ENT_W),
        .DEPTH(DEPTH),
        .AW(PW)
    ) u_mem (
        .clk(core_clk),
        .rstn(rstn),
        .wr_en(push),
        .wr_addr(wr_ptr_r),
        .wr_data(wr_entry),
        .rd_addr(rd_ptr_nxt),
        .rd_data_r(rd_entry)
    );

    // oldest entry presented; all outputs lag the buffer by one edge together
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_data_location <= `URB_BYTE_RST;
            rx_ninth_bit <= 1'b0;
        end
        else if (have_data)
        begin
            serial_data_location <= rd_entry[`URB_BYTE_W-1:0];
            rx_ninth_bit <= rd_entry[`URB_BYTE_W];
        end
        else
        begin
            serial_data_location <= `URB_BYTE_RST;
            rx_ninth_bit <= 1'b0;
        end
    end

    // error flags are read-only images of the oldest entry
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frame_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
        end
        else
        begin
            frame_error_flag <= have_data && rd_entry[`URB_FE_BIT];
            overrun_flag <= have_data && rd_entry[`URB_DOR_BIT];
            parity_error_flag <= have_data && parity_enable_bit &&
                rd_entry[`URB_PE_BIT];
        end
    end

    // complete flag and its request; error flags deliberately feed nothing here
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_complete_flag <= 1'b0;
            rx_complete_irq <= 1'b0;
        end
        else
        begin
            rx_complete_flag <= have_data;
            rx_complete_irq <= have_data && rx_complete_irq_enable &&
                global_irq_enable;
        end
    end

    // pin handed back to the port while disabled
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_pin_override <= 1'b0;
            rx_busy <= 1'b0;
        end
        else
        begin
            rx_pin_override <= rx_enable_bit;
            rx_busy <= (state_nxt != URB_ST_IDLE);
        end
    end

endmodule : urb_rx_status

// file: logic/urb_regs.svh
`ifndef URB_REGS_SVH
`define URB_REGS_SVH

// receive buffer depth and data width
`define URB_DEPTH 2
`define URB_DATA_W 9
`define URB_BYTE_W 8

// buffer entry layout: data, then the three error flags
`define URB_ENT_W 12
`define URB_FE_BIT 9
`define URB_DOR_BIT 10
`define URB_PE_BIT 11

// character size field codes and bit counts
`define URB_CSZ_W 3
`define URB_CSZ_NINE 3'h7
`define URB_CSZ_BASE 4'h5
`define URB_BITS_EIGHT 4'h8
`define URB_BITS_NINE 4'h9
`define URB_CSZ_MAX_STD 3'h3

// bit index width and reset values
`define URB_IDX_W 4
`define URB_IDX_ONE 4'h1
`define URB_IDX_RST 4'h0
`define URB_SHIFT_RST 9'h000
`define URB_ENT_RST 12'h000
`define URB_BYTE_RST 8'h00

`endif

// file: logic/urb_pkg.sv
package urb_pkg;

    // receive sequencer states, one-hot
    typedef enum logic [4:0] {
        URB_ST_IDLE = 5'h01,
        URB_ST_DATA = 5'h02,
        URB_ST_PAR = 5'h04,
        URB_ST_STOP = 5'h08,
        URB_ST_HOLD = 5'h10
    } urb_rx_state_t;

endpackage : urb_pkg

// file: logic/urb_fifo_mem.sv
`timescale 1ns/100ps
`include "urb_regs.svh"

// small entry store with a registered read port
module urb_fifo_mem #(
    parameter int WIDTH = `URB_ENT_W,
    parameter int DEPTH = `URB_DEPTH,
    parameter int AW = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_r
);

    logic [WIDTH-1:0] mem_r [DEPTH];

    generate
        if (DEPTH > (1 << AW))
        begin : g_bad_aw
            $error("urb_fifo_mem: address too narrow for depth");
        end
    endgenerate

    // storage itself needs no reset, every entry is written before use
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // write-first so an entry pushed into an empty store shows at once
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data_r <= '0;
        end
        else if (wr_en && (wr_addr == rd_addr))
        begin
            rd_data_r <= wr_data;
        end
        else
        begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

endmodule : urb_fifo_mem

// file: bench/urb_rx_status_assertions.sv
`timescale 1ns/100ps
`include "urb_regs.svh"

// port-level checks of the receive status block
module urb_rx_status_assertions #(
    parameter int DEPTH = `URB_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic rx_enable_bit,
    input wire logic rx_complete_irq_enable,
    input wire logic global_irq_enable,
    input wire logic parity_enable_bit,
    input wire logic parity_odd_select,
    input wire logic [`URB_CSZ_W-1:0] char_size_field,
    input wire logic start_detect,
    input wire logic bit_strobe,
    input wire logic bit_value,
    input wire logic data_read,
    input wire logic [`URB_BYTE_W-1:0] serial_data_location,
    input wire logic rx_ninth_bit,
    input wire logic frame_error_flag,
    input wire logic overrun_flag,
    input wire logic parity_error_flag,
    input wire logic rx_complete_flag,
    input wire logic rx_complete_irq,
    input wire logic rx_pin_override,
    input wire logic rx_busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // everything the empty buffer shows
    sequence s_cleared;
        !rx_complete_flag && serial_data_location == 8'h00 && !rx_ninth_bit
            && !frame_error_flag && !overrun_flag && !parity_error_flag;
    endsequence
    sequence s_irq_cond;
        rx_complete_flag && rx_complete_irq_enable && global_irq_enable;
    endsequence

    property p_irq_on;
        s_irq_cond ##1 s_irq_cond |-> rx_complete_irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("irq missing");
    property p_irq_off;
        (!rx_complete_irq_enable || !global_irq_enable) [*2] |-> !rx_complete_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq while masked");
    // error flags alone must never request
    property p_err_no_irq;
        !rx_complete_flag [*2] |-> !rx_complete_irq;
    endproperty
    a_err_no_irq: assert property (p_err_no_irq)
        else $error("irq without complete flag");
    // pin lets go one edge after the drop, the presented entry one edge later
    property p_disable_clear;
        !rx_enable_bit |=> !rx_pin_override ##1 s_cleared;
    endproperty
    a_disable_clear: assert property (p_disable_clear)
        else $error("buffer not flushed on disable");
    property p_override;
        rx_enable_bit [*2] |-> rx_pin_override;
    endproperty
    a_override: assert property (p_override)
        else $error("pin not taken while enabled");
    property p_par_off;
        !parity_enable_bit [*2] |-> !parity_error_flag;
    endproperty
    a_par_off: assert property (p_par_off)
        else $error("parity flag with checking off");
    property p_empty_zero;
        !rx_complete_flag |-> s_cleared;
    endproperty
    a_empty_zero: assert property (p_empty_zero)
        else $error("empty buffer shows data");
    // three strobe-free cycles rule out a push in flight
    property p_read_empty;
        !rx_complete_flag && data_read && !bit_strobe && !$past(bit_strobe) && !$past(bit_strobe, 2)
            |=> !rx_complete_flag;
    endproperty
    a_read_empty: assert property (p_read_empty)
        else $error("empty read changed state");
    property p_rise;
        $rose(rx_complete_flag) |-> $past(bit_strobe, 2);
    endproperty
    a_rise: assert property (p_rise)
        else $error("flag rose without a stop strobe");
    property p_head_stable;
        rx_complete_flag && rx_enable_bit && !data_read && !$past(data_read) && !$past(data_read, 2)
            |=> $stable(serial_data_location) && $stable(rx_ninth_bit)
            && $stable(frame_error_flag) && $stable(overrun_flag);
    endproperty
    a_head_stable: assert property (p_head_stable)
        else $error("head entry moved without a read");
endmodule : urb_rx_status_assertions

bind urb_rx_status urb_rx_status_assertions #(.DEPTH(DEPTH)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .rx_enable_bit(rx_enable_bit),
    .rx_complete_irq_enable(rx_complete_irq_enable), .global_irq_enable(global_irq_enable),
    .parity_enable_bit(parity_enable_bit), .parity_odd_select(parity_odd_select),
    .char_size_field(char_size_field), .start_detect(start_detect), .bit_strobe(bit_strobe),
    .bit_value(bit_value), .data_read(data_read), .serial_data_location(serial_data_location),
    .rx_ninth_bit(rx_ninth_bit), .frame_error_flag(frame_error_flag), .overrun_flag(overrun_flag),
    .parity_error_flag(parity_error_flag), .rx_complete_flag(rx_complete_flag),
    .rx_complete_irq(rx_complete_irq), .rx_pin_override(rx_pin_override), .rx_busy(rx_busy));

// file: bench/urb_tx_model.sv
`timescale 1ns/100ps

// remote transmitter as seen after clock and data recovery
module urb_tx_model (
    input wire logic core_clk,
    output logic start_detect,
    output logic bit_strobe,
    output logic bit_value
);
    initial
    begin
        start_detect = 1'h0;
        bit_strobe = 1'h0;
        bit_value = 1'h1;
    end

    // between strobes the line shows the inverse, so a stale bit never passes
    task automatic put_bit(input logic b, input int gap);
        @(negedge core_clk);
        bit_strobe = 1'h1;
        bit_value = b;
        @(negedge core_clk);
        bit_strobe = 1'h0;
        bit_value = ~b;
        repeat (gap) @(negedge core_clk);
    endtask : put_bit

    task automatic start_bit();
        @(negedge core_clk);
        start_detect = 1'h1;
        @(negedge core_clk);
        start_detect = 1'h0;
    endtask : start_bit

    // lsb first, optional parity, a single stop bit
    task automatic send_frame(input logic [8:0] d, input int nb, input logic pon, input logic pbit,
        input logic stop, input int gap);
        start_bit();
        for (int i = 0; i < nb; i++)
            put_bit(d[i], gap);
        if (pon)
            put_bit(pbit, gap);
        put_bit(stop, gap);
    endtask : send_frame
endmodule : urb_tx_model

// file: bench/urb_rx_status_tb.sv
`timescale 1ns/100ps
`include "urb_regs.svh"

// self-checking bench for the receive status block
module urb_rx_status_tb;
    logic core_clk, rstn, rx_enable_bit, rx_complete_irq_enable, global_irq_enable;
    logic parity_enable_bit, parity_odd_select, start_detect, bit_strobe, bit_value, data_read;
    logic [`URB_CSZ_W-1:0] char_size_field;
    logic [`URB_BYTE_W-1:0] serial_data_location;
    logic rx_ninth_bit, frame_error_flag, overrun_flag, parity_error_flag;
    logic rx_complete_flag, rx_complete_irq, rx_pin_override, rx_busy;
    int n_mismatch = 0;
    int n_checks = 0;

    urb_rx_status DUT (.core_clk(core_clk), .rstn(rstn), .rx_enable_bit(rx_enable_bit),
        .rx_complete_irq_enable(rx_complete_irq_enable), .global_irq_enable(global_irq_enable),
        .parity_enable_bit(parity_enable_bit), .parity_odd_select(parity_odd_select),
        .char_size_field(char_size_field), .start_detect(start_detect), .bit_strobe(bit_strobe),
        .bit_value(bit_value), .data_read(data_read), .serial_data_location(serial_data_location),
        .rx_ninth_bit(rx_ninth_bit), .frame_error_flag(frame_error_flag), .overrun_flag(overrun_flag),
        .parity_error_flag(parity_error_flag), .rx_complete_flag(rx_complete_flag),
        .rx_complete_irq(rx_complete_irq), .rx_pin_override(rx_pin_override), .rx_busy(rx_busy));
    urb_tx_model u_tx (.core_clk(core_clk), .start_detect(start_detect), .bit_strobe(bit_strobe),
        .bit_value(bit_value));

    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // push lands two edges after the stop strobe; two spare cycles
    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask : settle

    // software reads status first, then pops the data location; status is never written
    task automatic rd();
        data_read = 1'h1;
        @(negedge core_clk);
        data_read = 1'h0;
        settle();
    endtask : rd

    task automatic chk_head(input logic [8:0] d, input logic [2:0] err);
        chk("flag", rx_complete_flag, 1'h1);
        chk("data", serial_data_location, d[7:0]);
        chk("ninth", rx_ninth_bit, d[8]);
        chk("errors", {frame_error_flag, overrun_flag, parity_error_flag}, err);
    endtask : chk_head

    task automatic t_basic();
        rx_complete_irq_enable = 1'h1;
        global_irq_enable = 1'h1;
        u_tx.send_frame(9'h0A5, 8, 1'h0, 1'h0, 1'h1, 0);
        settle();
        chk_head(9'h0A5, 3'h0);
        chk("irq", rx_complete_irq, 1'h1);
        global_irq_enable = 1'h0;
        settle();
        chk("irq masked", rx_complete_irq, 1'h0);
        rd();
        chk("flag after read", rx_complete_flag, 1'h0);
        rd();
        chk("empty read", rx_complete_flag, 1'h0);
        $display("t_basic done");
    endtask : t_basic

    task automatic t_sizes();
        // last code is reserved and must behave as eight bits
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
        int nb;
        for (int k = 0; k < 6; k++)
        begin
            char_size_field = codes[k];
            nb = (k == 4) ? 9 : (k == 5) ? 8 : k + 5;
            u_tx.send_frame(9'h1FF, nb, 1'h0, 1'h0, 1'h1, k);
            settle();
            chk_head(9'h1FF >> (9 - nb), 3'h0);
            rd();
        end
        char_size_field = 3'h3;
        $display("t_sizes done");
    endtask : t_sizes

    // k[1] odd select, k[0] corrupt parity and break the stop bit
    task automatic t_parity();
        logic odd, bad;
        parity_enable_bit = 1'h1;
        for (int k = 0; k < 4; k++)
        begin
            odd = k[1];
            bad = k[0];
            parity_odd_select = odd;
            u_tx.send_frame(9'h0B3, 8, 1'h1, (^8'hB3) ^ odd ^ bad, ~bad, 0);
            settle();
            chk_head(9'h0B3, {bad, 1'h0, bad});
            rd();
        end
        // even sense, so a cleared parity bit is a mismatch
        parity_odd_select = 1'h0;
        u_tx.send_frame(9'h0B3, 8, 1'h1, 1'h0, 1'h1, 0);
        settle();
        chk("pe stored", parity_error_flag, 1'h1);
        parity_enable_bit = 1'h0;
        settle();
        chk("pe masked", parity_error_flag, 1'h0);
        rd();
        u_tx.send_frame(9'h0B3, 8, 1'h0, 1'h0, 1'h1, 0);
        settle();
        parity_enable_bit = 1'h1;
        settle();
        chk("pe unchecked", parity_error_flag, 1'h0);
        rd();
        parity_enable_bit = 1'h0;
        $display("t_parity done");
    endtask : t_parity

    // two fill the buffer, third waits, fourth start drops the third
    task automatic t_overrun();
        logic [8:0] d [5] = '{9'h011, 9'h022, 9'h033, 9'h044, 9'h055};
        for (int k = 0; k < 4; k++)
            u_tx.send_frame(d[k], 8, 1'h0, 1'h0, 1'h1, 0);
        settle();
        chk_head(d[0], 3'h0);
        rd();
        chk_head(d[1], 3'h0);
        rd();
        chk_head(d[3], 3'h2);
        rd();
        chk("drained", rx_complete_flag, 1'h0);
        u_tx.send_frame(d[4], 8, 1'h0, 1'h0, 1'h1, 0);
        settle();
        chk_head(d[4], 3'h0);
        rd();
        $display("t_overrun done");
    endtask : t_overrun

    task automatic t_disable();
        u_tx.send_frame(9'h066, 8, 1'h0, 1'h0, 1'h1, 0);
        u_tx.start_bit();
        u_tx.put_bit(1'h1, 0);
        chk("busy", rx_busy, 1'h1);
        rx_enable_bit = 1'h0;
        settle();
        chk("flushed", rx_complete_flag, 1'h0);
        chk("idle", rx_busy, 1'h0);
        chk("pin released", rx_pin_override, 1'h0);
        rx_enable_bit = 1'h1;
        settle();
        chk("pin taken", rx_pin_override, 1'h1);
        u_tx.send_frame(9'h077, 8, 1'h0, 1'h0, 1'h1, 0);
        settle();
        chk_head(9'h077, 3'h0);
        rd();
        $display("t_disable done");
    endtask : t_disable

    initial
    begin
        rstn = 1'h0;
        rx_enable_bit = 1'h0;
        rx_complete_irq_enable = 1'h0;
        global_irq_enable = 1'h0;
        parity_enable_bit = 1'h0;
        parity_odd_select = 1'h0;
        char_size_field = 3'h3;
        data_read = 1'h0;
        repeat (4) @(negedge core_clk);
        rstn = 1'h1;
        @(negedge core_clk);
        rx_enable_bit = 1'h1;
        @(negedge core_clk);
        t_basic();
        t_sizes();
        t_parity();
        t_overrun();
        t_disable();
        test_done();
    end
endmodule : urb_rx_status_tb
